/* File: timer_zero_counter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "timer_zero_cfg.svh"

// Functional notes
// - wide select: 1 gives 16-bit, 0 8-bit
// - 8-bit: count to buffered period, clear, reload
// - wide low read latches counter high byte
// - wide low write loads high byte too
// - wide counter wraps to zero, runs freely
// - wide and enabled: count writes ignored
// - three-bit field selects eight clock sources
// - synchronous: fosc/4 paced, halted in sleep
// - asynchronous: every rising edge, sleeps on, wakes
// - hidden prescaler, sixteen ratios to 1:32768
// - prescaler cleared by low/control writes, reset
// - postscaler divides events by field plus one
// - postscaler cleared by low/control writes, reset
// - output toggles per postscaled event, readable
// - flag set whenever output toggles
// - interrupt requested when flag and enable
// - enable bit seven runs module; controls reset zero
// - prescale 1111 divides by 32768
module timer_zero_counter
    import timer_zero_pkg::*;
#(
    parameter int PRESC_W = `CFG_PRESC_W
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // register port
    input wire reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    // clock sources and power state
    input wire clk_sources_t clk_sources_i,
    input wire logic sleep_i,
    // timer results
    output logic timer_output_signal_o,
    output logic irq_o,
    output logic wake_o
);

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (PRESC_W < `CFG_PRESC_W) begin : g_bad_width
        $error("prescaler too narrow for the largest ratio");
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic hit(input logic [`CFG_ADDR_W-1:0] a,
                                 input logic [`CFG_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // low n bits set: ratio two to the n
    function automatic logic [PRESC_W-1:0] ratio_mask(input logic [3:0] sel);
        ratio_mask = ~({PRESC_W{1'b1}} << sel);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    control_a_t ctrl_a_q, ctrl_a_d;
    control_b_t ctrl_b_q, ctrl_b_d;
    logic [7:0] lo_q, lo_d;
    logic [7:0] hi_cnt_q, hi_cnt_d;
    logic [7:0] hi_reg_q, hi_reg_d;
    logic [7:0] period_buf_q, period_buf_d;
    logic [PRESC_W-1:0] presc_q, presc_d;
    logic [3:0] post_q, post_d;
    logic out_q, out_d;
    logic pend_q, pend_d;
    logic flag_q, flag_d;
    logic ie_q, ie_d;
    logic src_prev_q, src_prev_d;
    logic fosc_prev_q, fosc_prev_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic wake_q, wake_d;

    logic [7:0] src_vec;
    logic src_now;
    logic src_evt;
    logic fosc_rise;
    logic wr_low, wr_high, wr_ca, wr_cb, wr_irq, rd_low;
    logic wide;
    logic unsynchronised_input_mode;
    logic run;
    logic scaler_clear;
    logic presc_tick;
    logic tick;
    logic roll;
    logic toggle;
    logic [15:0] wide_next;

    // ----------------------------------------
    // source selection and edges
    // ----------------------------------------
    // sources are sampled levels; edge found against last sample
    assign src_vec = {clk_sources_i.logic_cell_one_output,
                      clk_sources_i.secondary_oscillator,
                      clk_sources_i.mid_freq_internal_osc,
                      clk_sources_i.low_freq_internal_osc,
                      clk_sources_i.high_freq_internal_osc,
                      clk_sources_i.fosc_div4,
                      ~clk_sources_i.input_pin,
                      clk_sources_i.input_pin};
    assign src_now = src_vec[ctrl_b_q.clock_source];
    assign src_evt = src_now & ~src_prev_q;
    assign fosc_rise = clk_sources_i.fosc_div4 & ~fosc_prev_q;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    assign wr_low = reg_req_i.wr & hit(reg_req_i.addr, `CFG_OFF_COUNT_LOW);
    assign wr_high = reg_req_i.wr & hit(reg_req_i.addr, `CFG_OFF_COUNT_HIGH);
    assign wr_ca = reg_req_i.wr & hit(reg_req_i.addr, `CFG_OFF_CONTROL_A);
    assign wr_cb = reg_req_i.wr & hit(reg_req_i.addr, `CFG_OFF_CONTROL_B);
    assign wr_irq = reg_req_i.wr & hit(reg_req_i.addr, `CFG_OFF_IRQ_STATUS);
    assign rd_low = reg_req_i.rd & hit(reg_req_i.addr, `CFG_OFF_COUNT_LOW);

    assign wide = ctrl_a_q.wide_mode_select;
    assign unsynchronised_input_mode = ctrl_b_q.unsynchronised_input;
    // synchronous mode stops in sleep; asynchronous keeps going
    assign run = ctrl_a_q.enable & (unsynchronised_input_mode | ~sleep_i);
    assign scaler_clear = wr_low | wr_ca | wr_cb;
    assign presc_tick = run & src_evt
        & ((presc_q & ratio_mask(ctrl_b_q.prescale_select))
           == ratio_mask(ctrl_b_q.prescale_select));
    // pending tick waits for the next fosc/4 edge: caps the rate
    assign tick = unsynchronised_input_mode ? presc_tick
                             : ((pend_q | presc_tick) & fosc_rise & ~sleep_i);
    assign wide_next = {hi_cnt_q, lo_q} + `CFG_WIDE_ONE;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        ctrl_a_d = ctrl_a_q;
        ctrl_b_d = ctrl_b_q;
        lo_d = lo_q;
        hi_cnt_d = hi_cnt_q;
        hi_reg_d = hi_reg_q;
        period_buf_d = period_buf_q;
        presc_d = presc_q;
        post_d = post_q;
        out_d = out_q;
        pend_d = pend_q;
        flag_d = flag_q;
        ie_d = ie_q;
        src_prev_d = src_now;
        fosc_prev_d = clk_sources_i.fosc_div4;
        rdata_d = `CFG_RESET_BYTE;
        roll = 1'b0;
        toggle = 1'b0;

        // hidden prescaler
        if (scaler_clear) begin
            presc_d = '0;
        end else if (run & src_evt) begin
            presc_d = presc_q + PRESC_W'(1);
        end
        if (unsynchronised_input_mode | ~run | scaler_clear) begin
            pend_d = 1'b0;
        end else begin
            pend_d = (pend_q | presc_tick) & ~fosc_rise;
        end

        // counter
        if (tick) begin
            if (wide) begin
                {hi_cnt_d, lo_d} = wide_next;
                roll = ({hi_cnt_q, lo_q} == `CFG_WIDE_MAX);
            end else if (lo_q == period_buf_q) begin
                lo_d = `CFG_RESET_BYTE;
                period_buf_d = hi_reg_q;
                roll = 1'b1;
            end else begin
                lo_d = lo_q + `CFG_BYTE_ONE;
            end
        end

        // count byte access; a write overrides a same-cycle count
        if (wr_low & ~(ctrl_a_q.enable & wide)) begin
            lo_d = reg_req_i.wdata;
            if (wide) begin
                hi_cnt_d = hi_reg_q;
            end
        end
        if (wr_high) begin
            hi_reg_d = reg_req_i.wdata;
        end
        if (rd_low & wide) begin
            hi_reg_d = hi_cnt_q;
        end

        // postscaler and output
        if (scaler_clear) begin
            post_d = 4'h0;
        end else if (roll) begin
            if (post_q == ctrl_a_q.postscale_select) begin
                post_d = 4'h0;
                out_d = ~out_q;
                toggle = 1'b1;
            end else begin
                post_d = post_q + `CFG_POST_ONE;
            end
        end

        // control registers; output level bit is read only
        if (wr_ca) begin
            ctrl_a_d = control_a_t'(reg_req_i.wdata);
            ctrl_a_d.reserved = 1'b0;
            ctrl_a_d.out_level = 1'b0;
        end
        if (wr_cb) begin
            ctrl_b_d = control_b_t'(reg_req_i.wdata);
        end

        // flag: write one to clear, a set in the same cycle wins
        if (wr_irq) begin
            ie_d = reg_req_i.wdata[`CFG_IRQ_EN_BIT];
            if (reg_req_i.wdata[`CFG_IRQ_FLAG_BIT]) begin
                flag_d = 1'b0;
            end
        end
        if (toggle) begin
            flag_d = 1'b1;
        end

        // read data, valid the cycle after the strobe only
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                `CFG_OFF_COUNT_LOW: rdata_d = lo_q;
                `CFG_OFF_COUNT_HIGH: rdata_d = hi_reg_q;
                `CFG_OFF_CONTROL_A: begin
                    rdata_d = ctrl_a_q;
                    rdata_d[`CFG_OUT_BIT] = out_q;
                end
                `CFG_OFF_CONTROL_B: rdata_d = ctrl_b_q;
                `CFG_OFF_IRQ_STATUS: begin
                    rdata_d[`CFG_IRQ_FLAG_BIT] = flag_q;
                    rdata_d[`CFG_IRQ_EN_BIT] = ie_q;
                end
                default: rdata_d = `CFG_RESET_BYTE;
            endcase
        end

        irq_d = flag_d & ie_d;
        // only an asynchronous timer can run to wake the core
        wake_d = flag_d & ie_d & unsynchronised_input_mode & sleep_i;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_a_q <= control_a_t'(`CFG_RESET_BYTE);
            ctrl_b_q <= control_b_t'(`CFG_RESET_BYTE);
            lo_q <= `CFG_RESET_BYTE;
            hi_cnt_q <= `CFG_RESET_BYTE;
            hi_reg_q <= `CFG_RESET_BYTE;
            period_buf_q <= `CFG_RESET_BYTE;
            presc_q <= '0;
            post_q <= 4'h0;
            out_q <= 1'b0;
            pend_q <= 1'b0;
            flag_q <= 1'b0;
            ie_q <= 1'b0;
            src_prev_q <= 1'b0;
            fosc_prev_q <= 1'b0;
            rdata_q <= `CFG_RESET_BYTE;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            lo_q <= lo_d;
            hi_cnt_q <= hi_cnt_d;
            hi_reg_q <= hi_reg_d;
            period_buf_q <= period_buf_d;
            presc_q <= presc_d;
            post_q <= post_d;
            out_q <= out_d;
            pend_q <= pend_d;
            flag_q <= flag_d;
            ie_q <= ie_d;
            src_prev_q <= src_prev_d;
            fosc_prev_q <= fosc_prev_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            wake_q <= wake_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign timer_output_signal_o = out_q;
    assign irq_o = irq_q;
    assign wake_o = wake_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_wide_read_latch: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (rd_low & wide) |=> hi_reg_q == $past(hi_cnt_q))
        else $error("high byte not latched on low read");

    a_wide_write_load: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_low & wide & ~ctrl_a_q.enable) |=>
        {hi_cnt_q, lo_q} == {$past(hi_reg_q), $past(reg_req_i.wdata)})
        else $error("wide write did not load both bytes");

    a_wide_wrap: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (tick & wide & {hi_cnt_q, lo_q} == `CFG_WIDE_MAX & ~wr_low) |=>
        {hi_cnt_q, lo_q} == 16'h0000)
        else $error("wide counter did not wrap to zero");

    a_write_ignored: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_low & wide & ctrl_a_q.enable & ~tick) |=> $stable(lo_q) && $stable(hi_cnt_q))
        else $error("count written while running wide");

    a_period_match: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (tick & ~wide & lo_q == period_buf_q & ~wr_low) |=>
        lo_q == 8'h00 && period_buf_q == $past(hi_reg_q))
        else $error("period match did not clear and reload");

    a_sync_sleep_halt: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (~unsynchronised_input_mode & sleep_i & ~reg_req_i.wr)[*2] |=> $stable(lo_q) && $stable(hi_cnt_q))
        else $error("synchronous counter moved in sleep");

    a_prescale_clear: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_low | wr_ca | wr_cb) |=> presc_q == '0 && post_q == 4'h0)
        else $error("scalers not cleared by write");

    a_postscale_toggle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (roll & ~scaler_clear & post_q == ctrl_a_q.postscale_select) |=>
        out_q != $past(out_q) && post_q == 4'h0)
        else $error("output did not toggle at postscale count");

    a_flag_on_toggle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (out_q != $past(out_q)) |-> flag_q)
        else $error("flag not set when output toggled");

    a_irq_request: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (flag_q & ie_q) |-> irq_o)
        else $error("interrupt not requested");

    a_disabled_still: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (~ctrl_a_q.enable & ~reg_req_i.wr) |=> $stable(lo_q) && $stable(out_q))
        else $error("timer moved while disabled");

    a_narrow_step: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (tick & ~wide & lo_q != period_buf_q & ~wr_low) |=>
        lo_q == $past(lo_q) + `CFG_BYTE_ONE)
        else $error("narrow counter did not step by one");

    a_wide_step: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (tick & wide & ~wr_low) |=>
        {hi_cnt_q, lo_q} == $past({hi_cnt_q, lo_q}) + `CFG_WIDE_ONE)
        else $error("wide counter did not step by one");

    a_sync_rate: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (~unsynchronised_input_mode & ~fosc_rise & ~wr_low) |=> $stable(lo_q) && $stable(hi_cnt_q))
        else $error("synchronous counter stepped off the fosc/4 edge");

    a_wake_unsynchronised_input: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (flag_q & ie_q & unsynchronised_input_mode & sleep_i & ~reg_req_i.wr) |=> wake_o)
        else $error("asynchronous timer did not wake the core");

endmodule

`default_nettype wire

/* File: timer_zero_cfg.svh */
`ifndef TIMER_ZERO_CFG_SVH
`define TIMER_ZERO_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CFG_ADDR_W 12
`define CFG_OFF_COUNT_LOW 12'h019c
`define CFG_OFF_COUNT_HIGH 12'h019d
`define CFG_OFF_CONTROL_A 12'h019e
`define CFG_OFF_CONTROL_B 12'h019f
`define CFG_OFF_IRQ_STATUS 12'h01a0

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define CFG_RESET_BYTE 8'h00
`define CFG_IRQ_FLAG_BIT 0
`define CFG_IRQ_EN_BIT 1
`define CFG_OUT_BIT 5

// ----------------------------------------
// counting
// ----------------------------------------
`define CFG_PRESC_W 15
`define CFG_WIDE_MAX 16'hffff
`define CFG_WIDE_ONE 16'h0001
`define CFG_BYTE_ONE 8'h01
`define CFG_POST_ONE 4'h1

`endif

/* File: timer_zero_pkg.sv */
`include "timer_zero_cfg.svh"

package timer_zero_pkg;

    typedef struct packed {
        logic enable;
        logic reserved;
        logic out_level;
        logic wide_mode_select;
        logic [3:0] postscale_select;
    } control_a_t;

    typedef struct packed {
        logic [2:0] clock_source;
        logic unsynchronised_input;
        logic [3:0] prescale_select;
    } control_b_t;

    typedef enum logic [2:0] {
        SRC_PIN = 3'h0,
        SRC_PIN_INV = 3'h1,
        SRC_FOSC4 = 3'h2,
        SRC_HIGH_FREQ = 3'h3,
        SRC_LOW_FREQ = 3'h4,
        SRC_MID_FREQ = 3'h5,
        SRC_SECONDARY = 3'h6,
        SRC_LOGIC_CELL = 3'h7
    } clk_source_t;

    typedef struct packed {
        logic logic_cell_one_output;
        logic secondary_oscillator;
        logic mid_freq_internal_osc;
        logic low_freq_internal_osc;
        logic high_freq_internal_osc;
        logic fosc_div4;
        logic input_pin;
    } clk_sources_t;

    typedef struct packed {
        logic [`CFG_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

/* File: timer_zero_counter_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "timer_zero_cfg.svh"

module timer_zero_counter_tb
    import timer_zero_pkg::*;
();
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic core_clk;
    logic arst_n;
    reg_req_t req;
    logic [7:0] rdata;
    clk_sources_t srcs;
    logic sleep;
    logic out_sig;
    logic irq;
    logic wake;
    logic [3:0] cyc_q = 4'h0;
    logic run;
    logic [2:0] src_sel;
    logic sel_q = 1'b0;
    int edge_cnt = 0;
    int err_total;
    int checks_done;

    timer_zero_counter timer_zero_counter_inst (
        .core_clk_i(core_clk),
        .arst_n_i(arst_n),
        .reg_req_i(req),
        .reg_rdata_o(rdata),
        .clk_sources_i(srcs),
        .sleep_i(sleep),
        .timer_output_signal_o(out_sig),
        .irq_o(irq),
        .wake_o(wake)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // sources: fosc/4 free running, the rest only while run
    // ----------------------------------------
    always @(posedge core_clk) cyc_q <= cyc_q + 4'h1;
    assign srcs = {{5{run & cyc_q[2]}}, cyc_q[1], run & cyc_q[2]};

    // counts rising edges of the selected source as the design samples them
    always @(posedge core_clk) begin
        logic lvl;
        lvl = (src_sel < 3'h2) ? (srcs.input_pin ^ src_sel[0]) : srcs[src_sel - 3'h1];
        if (lvl && !sel_q) begin
            edge_cnt <= edge_cnt + 1;
        end
        sel_q <= lvl;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [`CFG_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [`CFG_ADDR_W-1:0] a, input logic [7:0] exp,
                          input string what, input logic [7:0] m = 8'hff);
        @(posedge core_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(negedge core_clk);
        check({8'h00, rdata & m}, {8'h00, exp}, what);
    endtask

    task automatic wait_toggle();
        logic prev;
        int i;
        prev = out_sig;
        for (i = 0; i < 6000; i++) begin
            @(negedge core_clk);
            if (out_sig !== prev) break;
        end
        if (i == 6000) check(16'h0000, 16'h0001, "output toggle timeout");
    endtask

    // first toggle only synchronises: the first period after setup may be short
    task automatic measure(input int exp_edges, input string what);
        int e0;
        wait_toggle();
        e0 = edge_cnt;
        wait_toggle();
        check(16'(edge_cnt - e0), 16'(exp_edges), what);
    endtask

    task automatic set_timer(input logic [2:0] src, input logic unsynchronised_input_in,
                             input logic [3:0] presc, input logic [3:0] post);
        @(posedge core_clk);
        run <= 1'b0;
        src_sel <= src;
        wr(`CFG_OFF_CONTROL_A, 8'h00);
        wr(`CFG_OFF_COUNT_HIGH, 8'h02);
        wr(`CFG_OFF_CONTROL_B, {src, unsynchronised_input_in, presc});
        wr(`CFG_OFF_CONTROL_A, {4'h8, post});
        @(posedge core_clk);
        run <= 1'b1;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(`CFG_OFF_CONTROL_A, 8'h00, "control a reset");
        rd_chk(`CFG_OFF_CONTROL_B, 8'h00, "control b reset");
        rd_chk(`CFG_OFF_COUNT_LOW, 8'h00, "low reset");
        rd_chk(`CFG_OFF_COUNT_HIGH, 8'h00, "high reset");
        rd_chk(`CFG_OFF_IRQ_STATUS, 8'h00, "irq status reset");
        check({13'h0000, out_sig, irq, wake}, 16'h0000, "outputs after reset");
        $display("test reset done");
    endtask

    // wide mode: load near the top, roll over, coherent reads, write refused
    task automatic t_wide();
        logic [15:0] val;
        int e0;
        wr(`CFG_OFF_CONTROL_A, 8'h10);
        wr(`CFG_OFF_CONTROL_B, 8'h10);
        wr(`CFG_OFF_IRQ_STATUS, 8'h02);
        wr(`CFG_OFF_COUNT_HIGH, 8'hff);
        wr(`CFG_OFF_COUNT_LOW, 8'hfd);
        wr(`CFG_OFF_CONTROL_A, 8'h90);
        @(negedge core_clk);
        e0 = edge_cnt;
        @(posedge core_clk);
        run <= 1'b1;
        repeat (48) @(posedge core_clk);
        run <= 1'b0;
        repeat (10) @(posedge core_clk);
        val = 16'hfffd + 16'(edge_cnt - e0);
        rd_chk(`CFG_OFF_COUNT_LOW, val[7:0], "wide low");
        wr(`CFG_OFF_COUNT_LOW, 8'h00);
        rd_chk(`CFG_OFF_COUNT_LOW, val[7:0], "wide low after write");
        rd_chk(`CFG_OFF_COUNT_HIGH, val[15:8], "latched high");
        rd_chk(`CFG_OFF_CONTROL_A, 8'hb0, "output bit after rollover");
        rd_chk(`CFG_OFF_IRQ_STATUS, 8'h03, "flag after rollover");
        check({15'h0000, irq}, 16'h0001, "irq request");
        @(posedge core_clk);
        sleep <= 1'b1;
        repeat (3) @(negedge core_clk);
        check({15'h0000, wake}, 16'h0001, "wake in unsynchronised_input sleep");
        // asynchronous and asleep: source edges still counted
        e0 = edge_cnt;
        @(posedge core_clk);
        run <= 1'b1;
        repeat (48) @(posedge core_clk);
        run <= 1'b0;
        repeat (10) @(posedge core_clk);
        val = val + 16'(edge_cnt - e0);
        rd_chk(`CFG_OFF_COUNT_LOW, val[7:0], "counting in unsynchronised_input sleep");
        // synchronous and asleep: edges ignored, no wake though flag pends
        wr(`CFG_OFF_CONTROL_B, 8'h00);
        @(posedge core_clk);
        run <= 1'b1;
        repeat (48) @(posedge core_clk);
        run <= 1'b0;
        repeat (10) @(negedge core_clk);
        check({15'h0000, wake}, 16'h0000, "no wake when sync");
        rd_chk(`CFG_OFF_COUNT_LOW, val[7:0], "halted in sleep");
        wr(`CFG_OFF_IRQ_STATUS, 8'h03);
        repeat (3) @(negedge core_clk);
        check({15'h0000, irq}, 16'h0000, "irq after clear");
        @(posedge core_clk);
        sleep <= 1'b0;
        $display("test wide done");
    endtask

    task automatic t_access();
        wr(`CFG_OFF_CONTROL_B, 8'ha5);
        rd_chk(`CFG_OFF_CONTROL_B, 8'ha5, "control b rw");
        wr(`CFG_OFF_CONTROL_A, 8'h1f);
        rd_chk(`CFG_OFF_CONTROL_A, 8'h1f, "control a rw", 8'hdf);
        wr(`CFG_OFF_COUNT_HIGH, 8'h5a);
        rd_chk(`CFG_OFF_COUNT_HIGH, 8'h5a, "high rw");
        wr(`CFG_OFF_CONTROL_A, 8'h00);
        wr(`CFG_OFF_COUNT_LOW, 8'h3c);
        rd_chk(`CFG_OFF_COUNT_LOW, 8'h3c, "low rw");
        wr(12'h000, 8'hff);
        rd_chk(12'h000, 8'h00, "unmapped");
        $display("test access done");
    endtask

    // narrow mode period 3, scaled by prescale and postscale
    task automatic t_narrow();
        logic [3:0] presc [3] = '{4'h0, 4'h0, 4'h2};
        logic [3:0] post [3] = '{4'h0, 4'hf, 4'h1};
        int exp [3] = '{3, 48, 24};
        for (int k = 0; k < 3; k++) begin
            set_timer(3'h0, 1'b1, presc[k], post[k]);
            measure(exp[k], "narrow period");
        end
        for (int s = 0; s < 8; s++) begin
            set_timer(3'(s), 1'b1, 4'h0, 4'h0);
            measure(3, "source select");
        end
        set_timer(3'h0, 1'b0, 4'h0, 4'h0);
        measure(3, "synchronous period");
        $display("test narrow done");
    endtask

    // reset in mid-run: everything back to its reset value
    task automatic t_mid_reset();
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (4) @(negedge core_clk);
        check({14'h0000, out_sig, irq}, 16'h0000, "outputs held in reset");
        @(posedge core_clk);
        run <= 1'b0;
        arst_n <= 1'b1;
        t_reset();
        $display("test mid reset done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        req = '0;
        run = 1'b0;
        sleep = 1'b0;
        src_sel = 3'h0;
        err_total = 0;
        checks_done = 0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_wide();
        t_access();
        t_narrow();
        t_mid_reset();
        finish_test();
    end

    // generous against a few thousand cycles of expected run time
    initial begin
        #500000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
